/* hdl/spb_pkg.sv */
// shared constants and types for the split-port burst sram pin logic
package spb_pkg;
   // ***************************************************
   // burst and latency
   // ***************************************************
   localparam int BURST_LEN = 4;
   localparam logic [1:0] LAST_BEAT = 2'h3;
   localparam logic [2:0] FETCH_DONE = 3'h4;
   // output edges from read request to first beat
   localparam logic [1:0] LAT_PLL_ON = 2'h3;
   localparam logic [1:0] LAT_PLL_OFF = 2'h2;
   localparam logic [1:0] EDGE_CNT_MAX = 2'h3;
   localparam int FIFO_DEPTH = 8;
   // synchroniser value after reset: pins idle high, so no false edge or select
   localparam logic SYNC_RST = 1'b1;

   typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_FETCH, RD_SEND} spb_rd_state_e;

   // nibble lanes on the 8-bit part, 9-bit lanes otherwise
   function automatic int lane_width(input int data_w);
      return (data_w == 8) ? 4 : 9;
   endfunction
endpackage

/* hdl/spb_mem_if.sv */
// array access port between the pin logic and the burst array
`timescale 1ns/1ps
`default_nettype none
interface spb_mem_if #(
   parameter int ADDR_W = 18,
   parameter int DATA_W = 18,
   parameter int NLANE = 2
);
   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [1:0] wr_word;
   logic [NLANE-1:0] wr_mask;
   logic [DATA_W-1:0] wr_data;
   logic rd_en;
   logic [ADDR_W-1:0] rd_addr;
   logic [1:0] rd_word;
   logic [DATA_W-1:0] rd_data;
   modport ctrl (output wr_en, wr_addr, wr_word, wr_mask, wr_data, rd_en, rd_addr, rd_word,
                 input rd_data);
   modport array (input wr_en, wr_addr, wr_word, wr_mask, wr_data, rd_en, rd_addr, rd_word,
                  output rd_data);
endinterface
`default_nettype wire

/* hdl/spb_fifo.sv */
// write beat queue with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module spb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = spb_pkg::FIFO_DEPTH
) (
   input wire logic sys_clk_in,              // system clock
   input wire logic reset_n_in,              // sync reset, active low
   input wire logic in_valid_in,             // push request
   output logic in_ready_out,                // room for a word
   input wire logic [WIDTH-1:0] in_data_in,  // pushed word
   output logic out_valid_out,               // word available
   input wire logic out_ready_in,            // drain accepts
   output logic [WIDTH-1:0] out_data_out     // head word
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);

   logic [WIDTH-1:0] store_q [DEPTH];
   logic [PW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
   logic [PW:0] count_q, count_d;
   logic push, pop;

   function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
      return (p == (PW)'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign in_ready_out = (count_q != FULL_CNT);
   assign out_valid_out = (count_q != '0);
   assign out_data_out = store_q[rd_ptr_q];
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;

   always_comb begin
      wr_ptr_d = push ? next_ptr(wr_ptr_q) : wr_ptr_q;
      rd_ptr_d = pop ? next_ptr(rd_ptr_q) : rd_ptr_q;
      count_d = count_q + (PW + 1)'(push) - (PW + 1)'(pop);
   end

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         count_q <= count_d;
      end
   end

   // storage carries no reset; count guards every read
   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         store_q[wr_ptr_q] <= in_data_in;
      end
   end
endmodule // spb_fifo
`default_nettype wire

/* hdl/spb_burst_array.sv */
// four sub-arrays, one per burst word, with lane write enables
`timescale 1ns/1ps
`default_nettype none
module spb_burst_array #(
   parameter int ADDR_W = 18,
   parameter int DATA_W = 18
) (
   input wire logic sys_clk_in,  // system clock
   input wire logic reset_n_in,  // sync reset, active low
   spb_mem_if.array mem          // access port
);
   localparam int LANE_W = spb_pkg::lane_width(DATA_W);
   localparam int NLANE = DATA_W / LANE_W;

   logic [DATA_W-1:0] cell_q [spb_pkg::BURST_LEN][2**ADDR_W];

   always_ff @(posedge sys_clk_in) begin
      if (mem.wr_en) begin
         for (int i = 0; i < NLANE; i++) begin
            if (mem.wr_mask[i]) begin
               cell_q[mem.wr_word][mem.wr_addr][i*LANE_W +: LANE_W] <=
                  mem.wr_data[i*LANE_W +: LANE_W];
            end
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         mem.rd_data <= '0;
      end else if (mem.rd_en) begin
         mem.rd_data <= cell_q[mem.rd_word][mem.rd_addr];
      end
   end
endmodule // spb_burst_array
`default_nettype wire

/* hdl/spb_sram_dev.sv */
// pin-level logic of the split-port four-word burst sram
// Summary of operation
// - write select low at input clock rise starts a write
// - deselected write port ignores data and leaves memory alone
// - 8-bit part: two nibble selects gate bits 3:0 and 7:4
// - wider parts: each byte select gates one 9-bit lane per beat
// - lanes with select high stay unchanged, enabled lanes update
// - one shared address bus, sampled at input clock rise
// - four sub-arrays, one per burst word; address 19/18/17 bits
// - address ignored for a deselected port
// - read beats launched on output clock rises, input clocks in single mode
// - read data tristated when the read port is idle
// - read select low at input clock rise starts a read
// - deselect lets burst finish, then drivers off after next positive output rise
// - every read returns four beats
// - both output clocks together time the read data, both input clocks in single mode
// - accesses begin on input clock rise; data on both input edges
// - pll bypass gives the shorter read latency
`timescale 1ns/1ps
`default_nettype none
module spb_sram_dev #(
   parameter int ADDR_W = 18, // address pins
   parameter int DATA_W = 18  // data pins per beat
) (
   input wire logic sys_clk_in,                      // system clock
   input wire logic reset_n_in,                      // sync reset, active low
   input wire logic in_clk_p_in,                     // positive input clock
   input wire logic in_clk_n_in,                     // negative input clock
   input wire logic out_clk_p_in,                    // positive output clock
   input wire logic out_clk_n_in,                    // negative output clock
   input wire logic write_port_select_n_in,          // write select, low active
   input wire logic read_port_select_n_in,           // read select, low active
   input wire logic pll_bypass_n_in,                 // low: short latency
   input wire logic single_clock_mode_in,            // read data on input clocks
   input wire logic [ADDR_W-1:0] addr_in,            // shared address
   input wire logic [DATA_W-1:0] wr_data_in,         // write data
   input wire logic [DATA_W/spb_pkg::lane_width(DATA_W)-1:0] byte_write_select_n_in, // lanes
   output logic [DATA_W-1:0] rd_data_out,            // read data
   output logic rd_data_oe_n_out                     // low while driving
);
   localparam int LANE_W = spb_pkg::lane_width(DATA_W);
   localparam int NLANE = DATA_W / LANE_W;
   localparam int BEAT_W = ADDR_W + 2 + NLANE + DATA_W;
   localparam int PIN_W = 8 + ADDR_W + DATA_W + NLANE;

   // ***************************************************
   // pin synchronisers and edge finders
   // ***************************************************
   logic [PIN_W-1:0] pin_raw, sync1_q, sync2_q;
   logic [3:0] clk_s, clk_prev_q, clk_rise;
   logic wr_sel_n_s, rd_sel_n_s, pllb_s, single_s;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] data_s;
   logic [NLANE-1:0] lane_sel_n_s;
   logic k_rise, kn_rise, oedge_p, oedge_n, oedge;

   // data and clocks share one pipeline, so sampling stays aligned
   assign pin_raw = {in_clk_p_in, in_clk_n_in, out_clk_p_in, out_clk_n_in,
                     write_port_select_n_in, read_port_select_n_in, pll_bypass_n_in,
                     single_clock_mode_in, addr_in, wr_data_in, byte_write_select_n_in};

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         sync1_q <= {PIN_W{spb_pkg::SYNC_RST}};
         sync2_q <= {PIN_W{spb_pkg::SYNC_RST}};
         clk_prev_q <= {4{spb_pkg::SYNC_RST}};
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         clk_prev_q <= clk_s;
      end
   end

   assign {clk_s, wr_sel_n_s, rd_sel_n_s, pllb_s, single_s, addr_s, data_s, lane_sel_n_s} = sync2_q;
   assign clk_rise = clk_s & ~clk_prev_q;
   assign k_rise = clk_rise[3];
   assign kn_rise = clk_rise[2];
   assign oedge_p = single_s ? k_rise : clk_rise[1];
   assign oedge_n = single_s ? kn_rise : clk_rise[0];
   assign oedge = oedge_p | oedge_n;

   // ***************************************************
   // write port
   // ***************************************************
   logic wr_busy_q, wr_busy_d;
   logic [1:0] wr_beat_q, wr_beat_d;
   logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
   logic beat_pend_q, beat_pend_d;
   logic [BEAT_W-1:0] beat_q, beat_d;
   logic wr_start, beat_edge;
   logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [BEAT_W-1:0] fifo_out_data;

   // write starts on input clock rise; address only when selected
   assign wr_start = k_rise & ~wr_sel_n_s & ~wr_busy_q;
   assign beat_edge = wr_busy_q & (k_rise | kn_rise);

   always_comb begin
      wr_busy_d = wr_busy_q;
      wr_beat_d = wr_beat_q;
      wr_addr_d = wr_addr_q;
      beat_pend_d = beat_pend_q;
      beat_d = beat_q;
      // held beat stalls here until the queue takes it
      if (beat_pend_q && fifo_in_ready) begin
         beat_pend_d = 1'b0;
      end
      if (wr_start) begin
         wr_busy_d = 1'b1;
         wr_beat_d = '0;
         wr_addr_d = addr_s;
      end else if (beat_edge) begin
         // lane selects sampled with the data
         beat_pend_d = 1'b1;
         beat_d = {wr_addr_q, wr_beat_q, ~lane_sel_n_s, data_s};
         wr_beat_d = wr_beat_q + 2'h1;
         if (wr_beat_q == spb_pkg::LAST_BEAT) begin
            wr_busy_d = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         wr_busy_q <= 1'b0;
         wr_beat_q <= '0;
         wr_addr_q <= '0;
         beat_pend_q <= 1'b0;
         beat_q <= '0;
      end else begin
         wr_busy_q <= wr_busy_d;
         wr_beat_q <= wr_beat_d;
         wr_addr_q <= wr_addr_d;
         beat_pend_q <= beat_pend_d;
         beat_q <= beat_d;
      end
   end

   spb_fifo #(.WIDTH(BEAT_W), .DEPTH(spb_pkg::FIFO_DEPTH)) u_fifo (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .in_valid_in(beat_pend_q),
      .in_ready_out(fifo_in_ready),
      .in_data_in(beat_q),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(fifo_out_ready),
      .out_data_out(fifo_out_data)
   );

   // ***************************************************
   // read port
   // ***************************************************
   spb_pkg::spb_rd_state_e rd_state_q, rd_state_d;
   logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
   logic [2:0] fetch_idx_q, fetch_idx_d;
   logic [1:0] send_idx_q, send_idx_d, edge_cnt_q, edge_cnt_d, lat_q, lat_d;
   logic [DATA_W-1:0] rbuf_q [spb_pkg::BURST_LEN];
   logic [DATA_W-1:0] rbuf_d [spb_pkg::BURST_LEN];
   logic [DATA_W-1:0] q_q, q_d;
   logic oe_q, oe_d, tail_q, tail_d, launch;

   spb_mem_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .NLANE(NLANE)) mem ();

   // latency in output edges
   // count excludes this edge, so beat 0 leaves on the latency-th edge
   assign launch = (rd_state_q == spb_pkg::RD_SEND) && oedge && (edge_cnt_q >= lat_q - 2'h1);

   always_comb begin
      rd_state_d = rd_state_q;
      rd_addr_d = rd_addr_q;
      fetch_idx_d = fetch_idx_q;
      send_idx_d = send_idx_q;
      edge_cnt_d = edge_cnt_q;
      lat_d = lat_q;
      rbuf_d = rbuf_q;
      q_d = q_q;
      oe_d = oe_q;
      tail_d = tail_q;
      if (oedge && edge_cnt_q != spb_pkg::EDGE_CNT_MAX) begin
         edge_cnt_d = edge_cnt_q + 2'h1;
      end
      // drivers off after next positive output rise
      if (tail_q && oedge_p) begin
         oe_d = 1'b0;
         tail_d = 1'b0;
      end
      unique case (rd_state_q)
         spb_pkg::RD_IDLE: begin
            // read starts on input clock rise
            if (k_rise && !rd_sel_n_s) begin
               rd_state_d = spb_pkg::RD_WAIT;
               rd_addr_d = addr_s;
               edge_cnt_d = '0;
               lat_d = pllb_s ? spb_pkg::LAT_PLL_ON : spb_pkg::LAT_PLL_OFF;
            end
         end
         spb_pkg::RD_WAIT: begin
            if (!wr_busy_q && !beat_pend_q && !fifo_out_valid) begin
               rd_state_d = spb_pkg::RD_FETCH;
               fetch_idx_d = '0;
            end
         end
         spb_pkg::RD_FETCH: begin
            fetch_idx_d = fetch_idx_q + 3'h1;
            if (fetch_idx_q != '0) begin
               rbuf_d[2'(fetch_idx_q - 3'h1)] = mem.rd_data;
            end
            if (fetch_idx_q == spb_pkg::FETCH_DONE) begin
               rd_state_d = spb_pkg::RD_SEND;
               send_idx_d = '0;
            end
         end
         spb_pkg::RD_SEND: begin
            if (launch) begin
               q_d = rbuf_q[send_idx_q];
               oe_d = 1'b1;
               tail_d = 1'b0;
               send_idx_d = send_idx_q + 2'h1;
               if (send_idx_q == spb_pkg::LAST_BEAT) begin
                  rd_state_d = spb_pkg::RD_IDLE;
                  tail_d = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         rd_state_q <= spb_pkg::RD_IDLE;
         rd_addr_q <= '0;
         fetch_idx_q <= '0;
         send_idx_q <= '0;
         edge_cnt_q <= '0;
         lat_q <= spb_pkg::LAT_PLL_ON;
         rbuf_q <= '{default: '0};
         q_q <= '0;
         oe_q <= 1'b0;
         tail_q <= 1'b0;
      end else begin
         rd_state_q <= rd_state_d;
         rd_addr_q <= rd_addr_d;
         fetch_idx_q <= fetch_idx_d;
         send_idx_q <= send_idx_d;
         edge_cnt_q <= edge_cnt_d;
         lat_q <= lat_d;
         rbuf_q <= rbuf_d;
         q_q <= q_d;
         oe_q <= oe_d;
         tail_q <= tail_d;
      end
   end

   assign rd_data_out = q_q;
   assign rd_data_oe_n_out = ~oe_q;

   // ***************************************************
   // array port: fetch pauses the drain, never both at once
   // ***************************************************
   assign fifo_out_ready = (rd_state_q != spb_pkg::RD_FETCH);
   assign mem.wr_en = fifo_out_valid & fifo_out_ready;
   assign {mem.wr_addr, mem.wr_word, mem.wr_mask, mem.wr_data} = fifo_out_data;
   assign mem.rd_en = (rd_state_q == spb_pkg::RD_FETCH) && !fetch_idx_q[2];
   assign mem.rd_addr = rd_addr_q;
   assign mem.rd_word = fetch_idx_q[1:0];

   spb_burst_array #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_array (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .mem(mem.array)
   );

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);

   a_wr_start_edge: assert property (
      wr_start |=> wr_busy_q && wr_beat_q == '0 && wr_addr_q == $past(addr_s))
      else $error("write did not start on input clock rise");
   a_wr_idle_quiet: assert property (
      !wr_busy_q && !beat_edge |=> !$rose(beat_pend_q))
      else $error("beat captured while write port idle");
   a_lane_mask_beat: assert property (
      beat_edge && !wr_start |=> beat_q[DATA_W +: NLANE] == ~$past(lane_sel_n_s))
      else $error("lane enables differ from sampled selects");
   a_addr_ignored: assert property (
      k_rise && rd_sel_n_s && rd_state_q == spb_pkg::RD_IDLE |=> rd_state_q == spb_pkg::RD_IDLE)
      else $error("read started while port deselected");
   a_rd_start_addr: assert property (
      k_rise && !rd_sel_n_s && rd_state_q == spb_pkg::RD_IDLE
      |=> rd_state_q == spb_pkg::RD_WAIT && rd_addr_q == $past(addr_s))
      else $error("read request not taken");
   a_burst_four: assert property (
      $fell(rd_state_q == spb_pkg::RD_SEND) |-> $past(send_idx_q) == spb_pkg::LAST_BEAT)
      else $error("read burst not four beats");
   a_launch_on_edge: assert property (
      $changed(q_q) |-> $past(launch) && $past(oedge))
      else $error("read data changed off an output edge");
   a_oe_release: assert property (
      tail_q && oedge_p && !launch |=> !oe_q ##1 !oe_q)
      else $error("drivers not released after burst");
   a_idle_tristate: assert property (
      rd_state_q == spb_pkg::RD_IDLE && !tail_q |-> !oe_q)
      else $error("read data driven while idle");
   a_fetch_coherent: assert property (
      rd_state_q == spb_pkg::RD_WAIT ##1 rd_state_q == spb_pkg::RD_FETCH
      |-> !$past(fifo_out_valid) && !$past(wr_busy_q) && !$past(beat_pend_q))
      else $error("fetch began with writes pending");
   a_first_latency: assert property (
      k_rise && !rd_sel_n_s && rd_state_q == spb_pkg::RD_IDLE && !pllb_s
      |=> lat_q == spb_pkg::LAT_PLL_OFF)
      else $error("bypass latency not taken");

   c_write_burst: cover property (wr_busy_q && wr_beat_q == spb_pkg::LAST_BEAT && beat_edge);
   c_read_burst: cover property (launch && send_idx_q == spb_pkg::LAST_BEAT);
   c_read_after_write: cover property (rd_state_q == spb_pkg::RD_WAIT && fifo_out_valid);
   c_partial_lanes: cover property (mem.wr_en && mem.wr_mask != '1);
endmodule // spb_sram_dev
`default_nettype wire

/* verif/spb_ctrl_model.sv */
// memory controller model: clock pairs, port selects, address and write beats
`timescale 1ns/1ps
`default_nettype none
module spb_ctrl_model #(
   parameter int AW = 18, // address pins
   parameter int DW = 18, // data pins
   parameter int NL = 2   // lane selects
) (
   input wire logic sys_clk_in,                   // system clock
   output logic in_clk_p_out,                     // positive input clock
   output logic in_clk_n_out,                     // negative input clock
   output logic out_clk_p_out,                    // positive output clock
   output logic out_clk_n_out,                    // negative output clock
   output logic write_port_select_n_out,          // write select
   output logic read_port_select_n_out,           // read select
   output logic [AW-1:0] addr_out,                // shared address
   output logic [DW-1:0] wr_data_out,             // write beat
   output logic [NL-1:0] byte_write_select_n_out  // lane selects
);
   initial begin
      in_clk_p_out = 1'b0;
      in_clk_n_out = 1'b1;
      out_clk_p_out = 1'b0;
      out_clk_n_out = 1'b1;
      write_port_select_n_out = 1'b1;
      read_port_select_n_out = 1'b1;
      addr_out = '0;
      wr_data_out = '0;
      byte_write_select_n_out = '1;
   end
   // ********************
   // one clock edge
   // ********************
   // pins move two cycles either side of an edge; clocks stand still when not run
   task automatic tick(input logic p, input logic kr, input logic cr, input logic wn,
      input logic rn, input logic [AW-1:0] a, input logic [DW-1:0] d, input logic dv,
      input logic [NL-1:0] bn);
      @(posedge sys_clk_in);
      write_port_select_n_out <= wn;
      read_port_select_n_out <= rn;
      addr_out <= (wn & rn) ? ~addr_out : a;
      wr_data_out <= dv ? d : ~wr_data_out;
      byte_write_select_n_out <= dv ? bn : ~byte_write_select_n_out;
      repeat (2) @(posedge sys_clk_in);
      if (kr) begin
         in_clk_p_out <= p;
         in_clk_n_out <= ~p;
      end
      if (cr) begin
         out_clk_p_out <= p;
         out_clk_n_out <= ~p;
      end
      @(posedge sys_clk_in);
   endtask
endmodule // spb_ctrl_model
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the split-port burst sram pin logic
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int AW = 18;
   localparam int DW = 18;
   localparam int NL = DW / spb_pkg::lane_width(DW);
   typedef struct packed {
      logic wr_on;
      logic [AW-1:0] addr;
      logic [DW-1:0] base;
      logic [7:0] lane_n;
      logic bypass_n;
      logic single;
   } spb_row_s;
   logic sys_clk, reset_n, k_p, k_n, c_p, c_n, wr_sel_n, rd_sel_n, bypass_n, single;
   logic [AW-1:0] addr;
   logic [DW-1:0] wr_data, rd_data;
   logic [NL-1:0] lane_sel_n;
   logic rd_oe_n, phase, k_run, c_run;
   int err_count, checked, edge_no, first_edge;
   logic [DW-1:0] beats[$];
   logic [DW-1:0] shadow[logic [AW+1:0]];
   spb_row_s rows[6];

   spb_sram_dev #(.ADDR_W(AW), .DATA_W(DW)) spb_sram_dev_i (
      .sys_clk_in(sys_clk), .reset_n_in(reset_n), .in_clk_p_in(k_p), .in_clk_n_in(k_n),
      .out_clk_p_in(c_p), .out_clk_n_in(c_n), .write_port_select_n_in(wr_sel_n),
      .read_port_select_n_in(rd_sel_n), .pll_bypass_n_in(bypass_n),
      .single_clock_mode_in(single), .addr_in(addr), .wr_data_in(wr_data),
      .byte_write_select_n_in(lane_sel_n), .rd_data_out(rd_data), .rd_data_oe_n_out(rd_oe_n));
   spb_ctrl_model #(.AW(AW), .DW(DW), .NL(NL)) spb_ctrl_model_i (
      .sys_clk_in(sys_clk), .in_clk_p_out(k_p), .in_clk_n_out(k_n), .out_clk_p_out(c_p),
      .out_clk_n_out(c_n), .write_port_select_n_out(wr_sel_n),
      .read_port_select_n_out(rd_sel_n), .addr_out(addr), .wr_data_out(wr_data),
      .byte_write_select_n_out(lane_sel_n));

   always #50 sys_clk = ~sys_clk;

   // ********************
   // shared tasks
   // ********************
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // one edge; the sample shows what the previous edge launched
   task automatic step(input logic wn, input logic rn, input logic [AW-1:0] a,
      input logic [DW-1:0] d, input logic dv, input logic [NL-1:0] bn);
      phase = ~phase;
      spb_ctrl_model_i.tick(phase, k_run, c_run, wn, rn, a, d, dv, bn);
      @(negedge sys_clk);
      edge_no++;
      if (rd_oe_n === 1'b0 && (beats.size() == 0 || beats[$] !== rd_data)) begin
         if (beats.size() == 0) first_edge = edge_no - 1;
         beats.push_back(rd_data);
      end
   endtask

   task automatic idle();
      step(1'b1, 1'b1, '0, '0, 1'b0, '1);
   endtask

   // stops only after a falling edge, so the clocks end low before the next frame
   task automatic drain();
      int n;
      for (n = 0; n < 24; n++) begin
         if (beats.size() >= 4 && rd_oe_n === 1'b1 && !phase) break;
         idle();
      end
      if (n == 24) begin
         err_count++;
         end_of_test();
      end
   endtask

   task automatic read_check(input logic [AW-1:0] a);
      check(DW'(beats.size()), DW'(4));
      for (int i = 0; i < 4; i++) check(beats[i], shadow[{a, 2'(i)}]);
      beats.delete();
   endtask

   task automatic do_reset();
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      check(rd_data, '0);
      check(DW'(rd_oe_n), DW'(1));
      @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask

   // write then a read of the same address two input edges later
   task automatic run_row(input spb_row_s r);
      logic [DW-1:0] d;
      @(posedge sys_clk);
      bypass_n <= r.bypass_n;
      single <= r.single;
      c_run = !r.single;
      step(!r.wr_on, 1'b1, r.addr, '0, 1'b0, '1);
      for (int i = 0; i < 4; i++) begin
         // low lane bits carry the word index, so adjacent beats always differ
         d = {r.base[DW-1:2], 2'(i)};
         if (r.wr_on && !r.lane_n[2*i]) shadow[{r.addr, 2'(i)}][8:0] = d[8:0];
         if (r.wr_on && !r.lane_n[2*i+1]) shadow[{r.addr, 2'(i)}][17:9] = d[17:9];
         // beats, read address on beat 1
         step(1'b1, i != 1, r.addr, d, 1'b1, r.lane_n[2*i +: 2]);
         if (i == 0) check(DW'(rd_oe_n), DW'(1));
      end
      idle();
      // only the selected clock pair runs
      k_run = r.single;
      drain();
      k_run = 1'b1;
      c_run = 1'b1;
      read_check(r.addr);
   endtask

   // ********************
   // main sequence
   // ********************
   initial begin
      int e0;
      sys_clk = 1'b0;
      reset_n = 1'b0;
      bypass_n = 1'b1;
      single = 1'b0;
      phase = 1'b0;
      k_run = 1'b1;
      c_run = 1'b1;
      err_count = 0;
      checked = 0;
      edge_no = 0;
      rows = '{'{1'b1, 18'h00000, 18'h12340, 8'h00, 1'b1, 1'b0},
               '{1'b1, 18'h3FFFF, 18'h2AAA8, 8'h00, 1'b0, 1'b0},
               '{1'b1, 18'h00001, 18'h15554, 8'h00, 1'b1, 1'b1},
               '{1'b1, 18'h00000, 18'h3C3C0, 8'h9C, 1'b1, 1'b0},
               '{1'b0, 18'h3FFFF, 18'h0F0F0, 8'h00, 1'b1, 1'b1},
               '{1'b1, 18'h00001, 18'h0A5A4, 8'h63, 1'b0, 1'b0}};
      do_reset();
      foreach (rows[r]) run_row(rows[r]);
      for (int b = 0; b < 2; b++) begin
         @(posedge sys_clk);
         bypass_n <= (b == 0);
         // lone read, a second request two edges after it is refused
         step(1'b1, 1'b0, 18'h00001, '0, 1'b0, '1);
         e0 = edge_no;
         idle();
         step(1'b1, 1'b0, 18'h3FFFF, '0, 1'b0, '1);
         drain();
         check(DW'(first_edge - e0), DW'(b ? spb_pkg::LAT_PLL_OFF : spb_pkg::LAT_PLL_ON));
         read_check(18'h00001);
      end
      // reset in the middle of a burst
      step(1'b1, 1'b0, 18'h00000, '0, 1'b0, '1);
      repeat (4) idle();
      do_reset();
      beats.delete();
      // reads resume after a mid-burst reset; K is high, so one edge first
      idle();
      step(1'b1, 1'b0, 18'h00001, '0, 1'b0, '1);
      drain();
      read_check(18'h00001);
      end_of_test();
   end
endmodule // tb
`default_nettype wire
